// *** logic/adch_host.sv ***
`timescale 1ns/100ps
`include "adch_defs.svh"

// Behaviour
// - plain variant result arrives complemented, eight bits
// - host supplies conversion clock and start pulse
// - plain variant raises end of conversion flag
// - plain variant drives data only when enabled
// - conversion clock comes from host serial clock
// - wait eoc, enable, read, invert, then disable
// - strobed variant uses four active-low control lines
// - chip select with write starts a conversion
// - chip select with read enables the data
// - active-low done line marks result ready
// - converter clock external or from own oscillator
// - chip select brackets every write or read strobe
// - start: write low inside chip select, release
// - wait at least 125 ns before sampling data
// - after sampling raise chip select and read
module adch_host
    import adch_pkg::*;
#(
    parameter logic [`ADCH_CNT_W-1:0] STEP_CYC = `ADCH_STEP_CYC,
    parameter logic [`ADCH_CNT_W-1:0] SK_HALF = `ADCH_SK_HALF
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // link to the converter
    adch_link_if.host bus,
    // user request
    input wire logic meas_req_i,
    input wire adch_variant_type variant_i,
    input wire logic sk_enable_i,
    // user answer
    output logic [`ADCH_DATA_W-1:0] result_o,
    output logic result_valid_o,
    output logic busy_o
);

    localparam logic [`ADCH_CNT_W-1:0] RD_CYC =
        `ADCH_CNT_W'(`ADCH_RD_CYC);

    adch_host_regs_type s_ff;
    adch_host_regs_type nxt_s;

    logic sk_run;
    logic step_done;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.valid = 1'b0;
        step_done = (s_ff.timer == 8'h00);
        if (!step_done) begin
            nxt_s.timer = s_ff.timer - 8'h01;
        end

        // serial clock: free-running, toggles every SK_HALF cycles when running
        sk_run = sk_enable_i || (variant_i == ADCH_VAR_PLAIN);
        if (sk_run) begin
            if (s_ff.sk_cnt == SK_HALF - 8'h01) begin
                nxt_s.sk_cnt = 8'h00;
                nxt_s.sk = !s_ff.sk;
            end else begin
                nxt_s.sk_cnt = s_ff.sk_cnt + 8'h01;
            end
        end else begin
            nxt_s.sk_cnt = 8'h00;
            nxt_s.sk = 1'b0;
        end

        case (s_ff.state)
            ADCH_H_IDLE: begin
                // a request is only taken once the last result is in
                if (meas_req_i) begin
                    nxt_s.busy = 1'b1;
                    nxt_s.timer = STEP_CYC;
                    if (variant_i == ADCH_VAR_PLAIN) begin
                        nxt_s.start = 1'b1;
                        nxt_s.state = ADCH_H_START;
                    end else begin
                        nxt_s.cs_n = 1'b0;
                        nxt_s.state = ADCH_H_CS_ON;
                    end
                end
            end
            ADCH_H_START: begin
                if (step_done) begin
                    nxt_s.start = 1'b0;
                    nxt_s.timer = STEP_CYC;
                    nxt_s.state = ADCH_H_STOP;
                end
            end
            ADCH_H_STOP: begin
                if (step_done) begin
                    nxt_s.state = ADCH_H_WAIT_EOC;
                end
            end
            ADCH_H_WAIT_EOC: begin
                if (bus.eoc) begin
                    nxt_s.oe = 1'b1;
                    nxt_s.timer = RD_CYC;
                    nxt_s.state = ADCH_H_OE_ON;
                end
            end
            ADCH_H_OE_ON: begin
                if (step_done) begin
                    nxt_s.result = ~bus.data_bus;
                    nxt_s.valid = 1'b1;
                    nxt_s.oe = 1'b0;
                    nxt_s.timer = STEP_CYC;
                    nxt_s.state = ADCH_H_OE_OFF;
                end
            end
            ADCH_H_OE_OFF: begin
                if (step_done) begin
                    nxt_s.busy = 1'b0;
                    nxt_s.state = ADCH_H_IDLE;
                end
            end
            ADCH_H_CS_ON: begin
                if (step_done) begin
                    nxt_s.wr_n = 1'b0;
                    nxt_s.timer = STEP_CYC;
                    nxt_s.state = ADCH_H_WR_ON;
                end
            end
            ADCH_H_WR_ON: begin
                if (step_done) begin
                    nxt_s.wr_n = 1'b1;
                    nxt_s.timer = STEP_CYC;
                    nxt_s.state = ADCH_H_WR_OFF;
                end
            end
            ADCH_H_WR_OFF: begin
                if (step_done) begin
                    nxt_s.cs_n = 1'b1;
                    nxt_s.timer = STEP_CYC;
                    nxt_s.state = ADCH_H_CS_OFF;
                end
            end
            ADCH_H_CS_OFF: begin
                if (step_done) begin
                    nxt_s.state = ADCH_H_WAIT_INT;
                end
            end
            ADCH_H_WAIT_INT: begin
                if (!bus.conversion_done_n) begin
                    nxt_s.cs_n = 1'b0;
                    nxt_s.timer = STEP_CYC;
                    nxt_s.state = ADCH_H_RCS_ON;
                end
            end
            ADCH_H_RCS_ON: begin
                if (step_done) begin
                    nxt_s.rd_n = 1'b0;
                    nxt_s.timer = RD_CYC;
                    nxt_s.state = ADCH_H_RD_ON;
                end
            end
            ADCH_H_RD_ON: begin
                if (step_done) begin
                    nxt_s.result = bus.data_bus;
                    nxt_s.valid = 1'b1;
                    nxt_s.rd_n = 1'b1;
                    nxt_s.timer = STEP_CYC;
                    nxt_s.state = ADCH_H_RD_OFF;
                end
            end
            ADCH_H_RD_OFF: begin
                if (step_done) begin
                    nxt_s.cs_n = 1'b1;
                    nxt_s.busy = 1'b0;
                    nxt_s.state = ADCH_H_IDLE;
                end
            end
            default: begin
                nxt_s.state = ADCH_H_IDLE;
                nxt_s.start = 1'b0;
                nxt_s.oe = 1'b0;
                nxt_s.cs_n = 1'b1;
                nxt_s.wr_n = 1'b1;
                nxt_s.rd_n = 1'b1;
                nxt_s.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_ff <= '{state: ADCH_H_IDLE, timer: 8'h00, sk_cnt: 8'h00,
                sk: 1'b0, start: 1'b0, oe: 1'b0, cs_n: 1'b1, wr_n: 1'b1,
                rd_n: 1'b1, result: 8'h00, valid: 1'b0, busy: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign bus.host_serial_clock_out = s_ff.sk;
    assign bus.start = s_ff.start;
    assign bus.oe = s_ff.oe;
    assign bus.cs_n = s_ff.cs_n;
    assign bus.wr_n = s_ff.wr_n;
    assign bus.rd_n = s_ff.rd_n;
    assign result_o = s_ff.result;
    assign result_valid_o = s_ff.valid;
    assign busy_o = s_ff.busy;

endmodule

// *** logic/adch_defs.svh ***
`ifndef ADCH_DEFS_SVH
`define ADCH_DEFS_SVH

// data path width of the converter result
`define ADCH_DATA_W 8
// system clock period in ns (125 MHz)
`define ADCH_CLK_NS 8
// least time from output enable to sampling the data lines, in ns
`define ADCH_T_RD_NS 125
// same time as whole clock cycles, rounded up
`define ADCH_RD_CYC ((`ADCH_T_RD_NS + `ADCH_CLK_NS - 1) / `ADCH_CLK_NS)
// half period of the host serial clock, in clock cycles
`define ADCH_SK_HALF 2
// one host instruction step lasts this many clock cycles plus one
`define ADCH_STEP_CYC 4
// divide ratio of the converter's own oscillator
`define ADCH_OSC_DIV 8
// width of the timers and dividers
`define ADCH_CNT_W 8
// value of the data lines with nobody driving (pull-ups)
`define ADCH_IDLE_DATA 8'hff
// first trial bit of a successive approximation
`define ADCH_MSB_MASK 8'h80
// last trial bit of a successive approximation
`define ADCH_LSB_MASK 8'h01

`endif

// *** logic/adch_pkg.sv ***
package adch_pkg;

    typedef enum logic {
        ADCH_VAR_PLAIN = 1'b0,
        ADCH_VAR_STROBED = 1'b1
    } adch_variant_type;

    typedef enum logic [2:0] {
        ADCH_D_IDLE = 3'b001,
        ADCH_D_CONV = 3'b010,
        ADCH_D_DONE = 3'b100
    } adch_dev_state_type;

    typedef enum logic [13:0] {
        ADCH_H_IDLE = 14'b00000000000001,
        ADCH_H_START = 14'b00000000000010,
        ADCH_H_STOP = 14'b00000000000100,
        ADCH_H_WAIT_EOC = 14'b00000000001000,
        ADCH_H_OE_ON = 14'b00000000010000,
        ADCH_H_OE_OFF = 14'b00000000100000,
        ADCH_H_CS_ON = 14'b00000001000000,
        ADCH_H_WR_ON = 14'b00000010000000,
        ADCH_H_WR_OFF = 14'b00000100000000,
        ADCH_H_CS_OFF = 14'b00001000000000,
        ADCH_H_WAIT_INT = 14'b00010000000000,
        ADCH_H_RCS_ON = 14'b00100000000000,
        ADCH_H_RD_ON = 14'b01000000000000,
        ADCH_H_RD_OFF = 14'b10000000000000
    } adch_host_state_type;

    typedef struct packed {
        adch_dev_state_type state;
        logic [7:0] sample;
        logic [7:0] result;
        logic [7:0] mask;
        logic clk_q;
        logic [7:0] osc_cnt;
        logic eoc;
        logic done_n;
        logic [7:0] dout;
        logic doe_n;
        logic busy;
    } adch_dev_regs_type;

    typedef struct packed {
        adch_host_state_type state;
        logic [7:0] timer;
        logic [7:0] sk_cnt;
        logic sk;
        logic start;
        logic oe;
        logic cs_n;
        logic wr_n;
        logic rd_n;
        logic [7:0] result;
        logic valid;
        logic busy;
    } adch_host_regs_type;

endpackage

// *** logic/adch_link_if.sv ***
`timescale 1ns/100ps
`include "adch_defs.svh"

interface adch_link_if;
    // host to converter
    logic host_serial_clock_out;
    logic start;
    logic oe;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    // converter to host
    logic eoc;
    logic conversion_done_n;
    logic [`ADCH_DATA_W-1:0] data_o;
    logic data_oe_n;
    // level on the shared data lines, pulled up when undriven
    logic [`ADCH_DATA_W-1:0] data_bus;

    assign data_bus = data_oe_n ? `ADCH_IDLE_DATA : data_o;

    modport dev (
        input host_serial_clock_out, start, oe, cs_n, wr_n, rd_n,
        output eoc, conversion_done_n, data_o, data_oe_n
    );

    modport host (
        output host_serial_clock_out, start, oe, cs_n, wr_n, rd_n,
        input eoc, conversion_done_n, data_bus
    );
endinterface

// *** logic/adch_converter.sv ***
`timescale 1ns/100ps
`include "adch_defs.svh"

module adch_converter
    import adch_pkg::*;
#(
    parameter logic [`ADCH_CNT_W-1:0] OSC_DIV = `ADCH_OSC_DIV
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // link to the host
    adch_link_if.dev bus,
    // user side
    input wire logic [`ADCH_DATA_W-1:0] sample_i,
    input wire adch_variant_type variant_i,
    input wire logic use_ext_clk_i,
    output logic busy_o
);

    adch_dev_regs_type s_ff;
    adch_dev_regs_type nxt_s;

    logic tick;
    logic start_evt;
    logic rd_en;
    logic [7:0] trial;

    always_comb begin
        nxt_s = s_ff;
        trial = s_ff.result | s_ff.mask;
        nxt_s.clk_q = bus.host_serial_clock_out;
        // plain variant always runs on the host clock
        if (variant_i == ADCH_VAR_PLAIN || use_ext_clk_i) begin
            tick = bus.host_serial_clock_out && !s_ff.clk_q;
        end else begin
            tick = (s_ff.osc_cnt == OSC_DIV - 8'h01);
        end
        nxt_s.osc_cnt = (s_ff.osc_cnt == OSC_DIV - 8'h01) ? 8'h00 :
            s_ff.osc_cnt + 8'h01;
        if (variant_i == ADCH_VAR_PLAIN) begin
            start_evt = bus.start;
            rd_en = bus.oe;
        end else begin
            start_evt = !bus.cs_n && !bus.wr_n;
            rd_en = !bus.cs_n && !bus.rd_n;
        end
        case (s_ff.state)
            ADCH_D_CONV: begin
                if (tick) begin
                    if (trial <= s_ff.sample) begin
                        nxt_s.result = trial;
                    end
                    nxt_s.mask = s_ff.mask >> 1;
                    if (s_ff.mask == `ADCH_LSB_MASK) begin
                        nxt_s.state = ADCH_D_DONE;
                        nxt_s.eoc = 1'b1;
                        nxt_s.done_n = 1'b0;
                        nxt_s.busy = 1'b0;
                    end
                end
            end
            ADCH_D_DONE: begin
                // in the strobed variant, reading the result withdraws the done line
                if (variant_i == ADCH_VAR_STROBED && rd_en) begin
                    nxt_s.done_n = 1'b1;
                end
            end
            default: begin
            end
        endcase
        // a start held active keeps the conversion at its first step
        if (start_evt) begin
            nxt_s.state = ADCH_D_CONV;
            nxt_s.sample = sample_i;
            nxt_s.result = 8'h00;
            nxt_s.mask = `ADCH_MSB_MASK;
            nxt_s.eoc = 1'b0;
            nxt_s.done_n = 1'b1;
            nxt_s.busy = 1'b1;
        end
        if (rd_en) begin
            nxt_s.doe_n = 1'b0;
            nxt_s.dout = (variant_i == ADCH_VAR_PLAIN) ? ~s_ff.result :
                s_ff.result;
        end else begin
            nxt_s.doe_n = 1'b1;
            nxt_s.dout = 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_ff <= '{state: ADCH_D_IDLE, sample: 8'h00, result: 8'h00,
                mask: 8'h00, clk_q: 1'b0, osc_cnt: 8'h00, eoc: 1'b0,
                done_n: 1'b1, dout: 8'h00, doe_n: 1'b1, busy: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign bus.eoc = s_ff.eoc;
    assign bus.conversion_done_n = s_ff.done_n;
    assign bus.data_o = s_ff.dout;
    assign bus.data_oe_n = s_ff.doe_n;
    assign busy_o = s_ff.busy;

endmodule

// *** dv/adch_link_checker.sv ***
`timescale 1ns/100ps

module adch_link_checker (
    // clock and reset
    input logic clk_i,
    input logic rst_n_i,
    // host to converter
    input logic host_serial_clock_out,
    input logic start,
    input logic oe,
    input logic cs_n,
    input logic wr_n,
    input logic rd_n,
    // converter to host
    input logic eoc,
    input logic conversion_done_n,
    input logic data_oe_n
);
    localparam int RD_MIN = 16;
    logic rd_en;
    logic [7:0] en_cnt_ff;

    assign rd_en = oe || (!cs_n && !rd_n);

    // cycles the output enable condition has been held
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !rd_en) begin
            en_cnt_ff <= 8'h00;
        end else if (en_cnt_ff != 8'hff) begin
            en_cnt_ff <= en_cnt_ff + 8'h01;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_drive_cause;
        !data_oe_n |-> $past(oe) || !($past(cs_n) || $past(rd_n));
    endproperty
    a_drive_cause: assert property (p_drive_cause)
        else $error("data driven without enable");
    property p_drive_on;
        $rose(rd_en) |=> !data_oe_n;
    endproperty
    a_drive_on: assert property (p_drive_on)
        else $error("data not driven after enable");
    property p_start_clr;
        start |=> !eoc;
    endproperty
    a_start_clr: assert property (p_start_clr)
        else $error("end flag kept during start");
    property p_eoc_quiet;
        $rose(eoc) |-> !start && !oe;
    endproperty
    a_eoc_quiet: assert property (p_eoc_quiet)
        else $error("end flag rose during start or read");
    property p_wr_clr;
        !cs_n && !wr_n |=> conversion_done_n;
    endproperty
    a_wr_clr: assert property (p_wr_clr)
        else $error("done kept low during start");
    property p_rd_clr;
        !cs_n && !rd_n |=> conversion_done_n;
    endproperty
    a_rd_clr: assert property (p_rd_clr)
        else $error("done kept low during read");
    property p_cs_bracket;
        !(wr_n && rd_n) |-> !cs_n;
    endproperty
    a_cs_bracket: assert property (p_cs_bracket)
        else $error("strobe outside chip select");
    property p_cs_lead;
        $fell(cs_n) |=> wr_n && rd_n;
    endproperty
    a_cs_lead: assert property (p_cs_lead)
        else $error("strobe together with chip select");
    property p_rd_wait;
        $rose(rd_n) || $fell(oe) |-> en_cnt_ff >= RD_MIN;
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read enable too short");
    property p_cs_after;
        $rose(rd_n) |-> ##[1:16] cs_n;
    endproperty
    a_cs_after: assert property (p_cs_after)
        else $error("chip select not released");
    property p_start_len;
        $rose(start) |-> start [*5] ##1 !start;
    endproperty
    a_start_len: assert property (p_start_len)
        else $error("start pulse length wrong");
    property p_sk_run;
        start |-> ##[1:4] $rose(host_serial_clock_out);
    endproperty
    a_sk_run: assert property (p_sk_run)
        else $error("no serial clock pulse during start");
endmodule

// *** dv/adch_test.sv ***
`timescale 1ns/100ps
`include "adch_defs.svh"

module adch_test;
    import adch_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic meas_req = 1'b0;
    logic sk_en = 1'b0;
    logic ext_clk = 1'b0;
    adch_variant_type variant = ADCH_VAR_PLAIN;
    logic [7:0] sample = 8'h00;
    logic [7:0] result;
    logic [7:0] wire_q;
    logic valid, host_busy, conv_busy;
    logic seen_ready = 1'b0;
    logic start_q = 1'b0;
    int starts = 0;
    int starts0 = 0;
    logic [7:0] pats [4] = '{8'h00, 8'hff, 8'h5a, 8'h81};
    int mismatches = 0;
    int num_checks = 0;

    adch_link_if link ();

    always #4 clk_i = ~clk_i;

    adch_host i_adch_host (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .bus(link),
        .meas_req_i(meas_req), .variant_i(variant), .sk_enable_i(sk_en),
        .result_o(result), .result_valid_o(valid), .busy_o(host_busy)
    );
    adch_converter i_adch_converter (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .bus(link),
        .sample_i(sample), .variant_i(variant),
        .use_ext_clk_i(ext_clk), .busy_o(conv_busy)
    );
    adch_link_checker i_adch_link_checker (
        .clk_i(clk_i), .rst_n_i(rst_n_i),
        .host_serial_clock_out(link.host_serial_clock_out),
        .start(link.start), .oe(link.oe), .cs_n(link.cs_n),
        .wr_n(link.wr_n), .rd_n(link.rd_n), .eoc(link.eoc),
        .conversion_done_n(link.conversion_done_n),
        .data_oe_n(link.data_oe_n)
    );

    // last value seen on the data lines and whether a done flag showed
    always @(posedge clk_i) begin
        if (!link.data_oe_n) wire_q <= link.data_bus;
        start_q <= link.start;
        if (link.start && !start_q) starts <= starts + 1;
        // a start clears the flag, so a stale done cannot count
        if (link.start || !(link.cs_n || link.wr_n)) seen_ready <= 1'b0;
        else if (variant == ADCH_VAR_PLAIN ? link.eoc :
                 !link.conversion_done_n) seen_ready <= 1'b1;
    end

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t flag %b exp %b", $time, got, exp);
        end
    endtask

    task automatic measure(input adch_variant_type v, input logic ext,
                           input logic [7:0] s, input int hold = 1);
        int n;
        @(posedge clk_i);
        variant <= v;
        ext_clk <= ext;
        sk_en <= ext;
        sample <= s;
        meas_req <= 1'b1;
        repeat (hold) @(posedge clk_i);
        meas_req <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (valid !== 1'b1 && n < 3000);
        check1(valid, 1'b1);
        check8(result, s);
        check8(wire_q, v == ADCH_VAR_PLAIN ? ~s : s);
        check1(seen_ready, 1'b1);
        check1(conv_busy, 1'b0);
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (host_busy !== 1'b0 && n < 3000);
        check1(host_busy, 1'b0);
        check1(link.data_oe_n, 1'b1);
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        mismatches++;
        complete_run();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            foreach (pats[i]) begin
                measure(k == 0 ? ADCH_VAR_PLAIN : ADCH_VAR_STROBED,
                        k == 1, pats[i]);
            end
        end
        // request held while busy must not start a second conversion
        starts0 = starts;
        measure(ADCH_VAR_PLAIN, 1'b0, 8'h3c, 3);
        repeat (60) @(posedge clk_i);
        #1;
        check1(host_busy, 1'b0);
        check1(starts - starts0 == 1, 1'b1);
        // reset in the middle of a strobed start
        @(posedge clk_i);
        variant <= ADCH_VAR_STROBED;
        meas_req <= 1'b1;
        @(posedge clk_i);
        meas_req <= 1'b0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        #1;
        check1(link.cs_n & link.wr_n & link.rd_n, 1'b1);
        check1(link.conversion_done_n, 1'b1);
        check1(link.data_oe_n | link.start, 1'b1);
        check8(link.data_bus, 8'hff);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        measure(ADCH_VAR_STROBED, 1'b0, 8'hc3);
        complete_run();
    end
endmodule
